//--- hdl/hsp_port.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - all input bits captured on rising edge
// - read MSB driven right after last command bit
// - later read bits shift out on falling edges
// - every register reachable at its own address
// - small status words each have an address of their own
// - decode addresses 000h to 01Ah per map
// - test select reroutes pins to boundary scan
// - reset pin becomes scan reset in test
// - reset clears every internal register but sets the select synchroniser high
// - serial out high impedance during reset; other outputs driven to reset values
// - command MSB first: direction, reserved, address
// - access is command word plus one data word
// - in port mode, serial out undriven unless chip selected
// - serial port enabled only with test select low
module hsp_port
  import hsp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic host_serial_clk,
  input wire logic host_select_n,
  input wire logic host_serial_in,
  output logic host_serial_out,
  output logic host_serial_out_oe,
  input wire logic test_port_select,
  output logic scan_enable,
  output logic scan_mode_select,
  output logic scan_clock,
  output logic scan_data_in,
  output logic scan_reset_n,
  input wire logic scan_data_out,
  input wire logic scan_data_out_en,
  input wire logic [15:0] fault_flags_in,
  input wire logic [15:0] checkword_flags_in,
  input wire logic [15:0] picture_std_in,
  input wire logic [31:0] payload_id_in,
  input wire logic [63:0] line_sample_in,
  output logic [15:0] processing_feature_disable,
  output logic [79:0] ancillary_packet_id_filters,
  output logic [127:0] check_window_bounds,
  output logic [15:0] fault_report_mask,
  output logic checkword_write,
  output logic [15:0] checkword_write_data
);
  // =====================================================================
  // state
  typedef struct packed {
    logic sclk_prev;
    logic [5:0] bit_cnt;
    logic [15:0] cmd;
    logic [15:0] rx;
    logic [15:0] tx;
    logic out_en;
    logic cw_wr;
    logic [15:0] cw_data;
    logic [HSP_CFG_WORDS-1:0][15:0] cfg;
  } hsp_state_t;

  hsp_state_t state_reg;
  hsp_state_t state_next;

  logic sclk_s;
  logic select_n_s;
  logic host_serial_in_s;
  logic test_s;

  // =====================================================================
  // pin synchronisers
  // select resets high and the rest low, like idle pins, so release makes no false edge
  hsp_sync #(.RESET_VALUE(1'b0)) u_sync_sclk
  (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(host_serial_clk),
    .sync_out(sclk_s)
  );

  hsp_sync #(.RESET_VALUE(1'b1)) u_sync_sel
  (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(host_select_n),
    .sync_out(select_n_s)
  );

  hsp_sync #(.RESET_VALUE(1'b0)) u_sync_host_serial_in
  (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(host_serial_in),
    .sync_out(host_serial_in_s)
  );

  hsp_sync #(.RESET_VALUE(1'b0)) u_sync_test
  (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(test_port_select),
    .sync_out(test_s)
  );

  // =====================================================================
  // address decode
  function automatic logic [16:0] read_word(input logic [5:0] addr, input hsp_state_t s,
                                            input logic [15:0] fault, input logic [15:0] cw,
                                            input logic [15:0] std, input logic [31:0] pay,
                                            input logic [63:0] ras);
    logic [16:0] r;
    logic [5:0] off;
    r = {1'b0, HSP_UNMAPPED_READ};
    // unmapped and reserved addresses keep the fixed read value
    off = 6'h00;
    if (addr == HSP_ADDR_FEATURE_DISABLE)
      r = {1'b1, s.cfg[HSP_IDX_FEATURE]};
    else if (addr == HSP_ADDR_FAULT_FLAGS)
      r = {1'b1, fault};
    else if (addr == HSP_ADDR_CHECKWORD_FLAGS)
      r = {1'b1, cw};
    else if (addr == HSP_ADDR_PICTURE_STD)
      r = {1'b1, std};
    else if (addr >= HSP_ADDR_ANC_FILTER_FIRST && addr <= HSP_ADDR_ANC_FILTER_LAST)
    begin
      off = addr - HSP_ADDR_ANC_FILTER_FIRST;
      r = {1'b1, s.cfg[HSP_IDX_ANC + off[3:0]]};
    end
    else if (addr >= HSP_ADDR_PAYLOAD_FIRST && addr <= HSP_ADDR_PAYLOAD_LAST)
    begin
      off = addr - HSP_ADDR_PAYLOAD_FIRST;
      r = {1'b1, pay[{off[0], 4'h0} +: 16]};
    end
    else if (addr >= HSP_ADDR_RASTER_FIRST && addr <= HSP_ADDR_RASTER_LAST)
    begin
      off = addr - HSP_ADDR_RASTER_FIRST;
      r = {1'b1, ras[{off[1:0], 4'h0} +: 16]};
    end
    else if (addr >= HSP_ADDR_WINDOW_FIRST && addr <= HSP_ADDR_WINDOW_LAST)
    begin
      off = addr - HSP_ADDR_WINDOW_FIRST;
      r = {1'b1, s.cfg[HSP_IDX_WINDOW + off[3:0]]};
    end
    else if (addr == HSP_ADDR_FAULT_MASK)
      r = {1'b1, s.cfg[HSP_IDX_MASK]};
    return r;
  endfunction

  // returns {hit, index} into the writable store
  function automatic logic [4:0] write_index(input logic [5:0] addr);
    logic [4:0] w;
    logic [5:0] off;
    w = 5'h00;
    // read-only and unmapped addresses give no hit, so such writes miss the store; a write to 03h still pulses checkword_write
    off = 6'h00;
    if (addr == HSP_ADDR_FEATURE_DISABLE)
      w = {1'b1, HSP_IDX_FEATURE};
    else if (addr >= HSP_ADDR_ANC_FILTER_FIRST && addr <= HSP_ADDR_ANC_FILTER_LAST)
    begin
      off = addr - HSP_ADDR_ANC_FILTER_FIRST;
      w = {1'b1, HSP_IDX_ANC + off[3:0]};
    end
    else if (addr >= HSP_ADDR_WINDOW_FIRST && addr <= HSP_ADDR_WINDOW_LAST)
    begin
      off = addr - HSP_ADDR_WINDOW_FIRST;
      w = {1'b1, HSP_IDX_WINDOW + off[3:0]};
    end
    else if (addr == HSP_ADDR_FAULT_MASK)
      w = {1'b1, HSP_IDX_MASK};
    return w;
  endfunction

  // =====================================================================
  // serial engine
  logic sclk_rise;
  logic sclk_fall;
  logic is_read;
  logic [15:0] cmd_full;
  logic [15:0] data_full;
  logic [16:0] rd;
  logic [4:0] wi;
  logic [5:0] cmd_addr;
  logic last_cmd_bit;
  logic last_data_bit;

  always_comb
  begin
    state_next = state_reg;
    state_next.sclk_prev = sclk_s;
    state_next.cw_wr = 1'b0;
    sclk_rise = sclk_s & ~state_reg.sclk_prev;
    sclk_fall = ~sclk_s & state_reg.sclk_prev;
    cmd_full = {state_reg.cmd[14:0], host_serial_in_s};
    data_full = {state_reg.rx[14:0], host_serial_in_s};
    is_read = state_reg.cmd[HSP_CMD_DIR_BIT];
    cmd_addr = state_reg.cmd[HSP_ADDR_LSB +: HSP_ADDR_W];
    last_cmd_bit = (state_reg.bit_cnt == HSP_CMD_LAST - 6'h01);
    last_data_bit = (state_reg.bit_cnt == HSP_DATA_LAST - 6'h01);
    rd = read_word(cmd_full[HSP_ADDR_LSB +: HSP_ADDR_W], state_reg, fault_flags_in, checkword_flags_in,
                   picture_std_in, payload_id_in, line_sample_in);
    wi = write_index(cmd_addr);
    if (test_s || select_n_s)
    begin
      // idle whenever deselected or in scan mode
      state_next.bit_cnt = 6'h00;
      state_next.out_en = 1'b0;
    end
    else if (sclk_rise && state_reg.bit_cnt < HSP_DATA_LAST)
    begin
      state_next.bit_cnt = state_reg.bit_cnt + 6'h01;
      if (state_reg.bit_cnt < HSP_CMD_LAST)
      begin
        state_next.cmd = cmd_full;
        if (last_cmd_bit && cmd_full[HSP_CMD_DIR_BIT])
        begin
          // msb is on the pin before the falling edge that closes the command
          state_next.tx = rd[15:0];
          state_next.out_en = 1'b1;
        end
      end
      else
      begin
        state_next.rx = data_full;
        // only the 32nd rise writes, so a cut frame never reaches the store
        if (last_data_bit && !is_read)
        begin
          if (wi[4])
            state_next.cfg[wi[3:0]] = data_full;
          if (cmd_addr == HSP_ADDR_CHECKWORD_FLAGS)
          begin
            state_next.cw_wr = 1'b1;
            state_next.cw_data = data_full;
          end
        end
      end
    end
    else if (sclk_fall && is_read && state_reg.bit_cnt > HSP_CMD_LAST)
    begin
      // the fall after the 32nd rise releases the pin
      if (state_reg.bit_cnt < HSP_DATA_LAST)
        state_next.tx = {state_reg.tx[14:0], 1'b0};
      else
        state_next.out_en = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  // =====================================================================
  // pin sharing and outputs
  always_comb
  begin
    // scan reset follows the pin itself: the synchronised test select is
    // cleared by reset, so gating on it would never let a scan reset through
    scan_reset_n = rst_n;
    if (test_s)
    begin
      // pins handed over to boundary scan
      scan_enable = rst_n;
      scan_mode_select = select_n_s;
      scan_clock = sclk_s;
      scan_data_in = host_serial_in_s;
      host_serial_out = scan_data_out;
      host_serial_out_oe = rst_n & scan_data_out_en;
    end
    else
    begin
      // scan side parked, the port owns its pin
      scan_enable = 1'b0;
      scan_mode_select = 1'b1;
      scan_clock = 1'b0;
      scan_data_in = 1'b1;
      host_serial_out = state_reg.tx[HSP_WORD_BITS-1];
      host_serial_out_oe = rst_n & state_reg.out_en & ~select_n_s;
    end
  end

  // =====================================================================
  // configuration outputs
  always_comb
  begin
    processing_feature_disable = state_reg.cfg[HSP_IDX_FEATURE];
    fault_report_mask = state_reg.cfg[HSP_IDX_MASK];
    for (int i = 0; i < 5; i++)
      ancillary_packet_id_filters[i*16 +: 16] = state_reg.cfg[int'(HSP_IDX_ANC) + i];
    for (int j = 0; j < 8; j++)
      check_window_bounds[j*16 +: 16] = state_reg.cfg[int'(HSP_IDX_WINDOW) + j];
    checkword_write = state_reg.cw_wr;
    checkword_write_data = state_reg.cw_data;
  end
endmodule // hsp_port
`default_nettype wire

//--- include/hsp_pkg.sv
`default_nettype none
package hsp_pkg;
  // serial framing
  localparam int HSP_WORD_BITS = 16;
  localparam logic [5:0] HSP_CMD_LAST = 6'h10;
  localparam logic [5:0] HSP_DATA_LAST = 6'h20;
  localparam int HSP_CMD_DIR_BIT = 15;
  localparam int HSP_ADDR_LSB = 0;
  localparam int HSP_ADDR_W = 6;
  // host timing figures
  localparam real HSP_SCLK_MAX_MHZ = 6.6;
  localparam int HSP_CLK_NS = 10;
  localparam int HSP_RD_VALID_NS = 12;
  localparam int HSP_RD_VALID_CYC = (HSP_RD_VALID_NS / HSP_CLK_NS) < 1 ? 1 : (HSP_RD_VALID_NS / HSP_CLK_NS);
  localparam int HSP_RESET_MS = 1;
  localparam int HSP_RESET_CYC = HSP_RESET_MS * 1000000 / HSP_CLK_NS;
  // register map
  localparam logic [5:0] HSP_ADDR_FEATURE_DISABLE = 6'h00;
  localparam logic [5:0] HSP_ADDR_FAULT_FLAGS = 6'h01;
  localparam logic [5:0] HSP_ADDR_CHECKWORD_FLAGS = 6'h03;
  localparam logic [5:0] HSP_ADDR_PICTURE_STD = 6'h04;
  localparam logic [5:0] HSP_ADDR_ANC_FILTER_FIRST = 6'h05;
  localparam logic [5:0] HSP_ADDR_ANC_FILTER_LAST = 6'h09;
  localparam logic [5:0] HSP_ADDR_PAYLOAD_FIRST = 6'h0C;
  localparam logic [5:0] HSP_ADDR_PAYLOAD_LAST = 6'h0D;
  localparam logic [5:0] HSP_ADDR_RASTER_FIRST = 6'h0E;
  localparam logic [5:0] HSP_ADDR_RASTER_LAST = 6'h11;
  localparam logic [5:0] HSP_ADDR_WINDOW_FIRST = 6'h12;
  localparam logic [5:0] HSP_ADDR_WINDOW_LAST = 6'h19;
  localparam logic [5:0] HSP_ADDR_FAULT_MASK = 6'h1A;
  // writable word store: feature(0) anc(1..5) window(6..13) mask(14)
  localparam int HSP_CFG_WORDS = 15;
  localparam logic [3:0] HSP_IDX_FEATURE = 4'h0;
  localparam logic [3:0] HSP_IDX_ANC = 4'h1;
  localparam logic [3:0] HSP_IDX_WINDOW = 4'h6;
  localparam logic [3:0] HSP_IDX_MASK = 4'hE;
  localparam logic [15:0] HSP_CFG_RESET = 16'h0000;
  localparam logic [15:0] HSP_UNMAPPED_READ = 16'h0000;
endpackage
`default_nettype wire

//--- hdl/hsp_sync.sv
`timescale 1ns/1ps
`default_nettype none
module hsp_sync
  import hsp_pkg::*;
#(
  parameter logic RESET_VALUE = 1'b0
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_reg;
  logic sync_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= RESET_VALUE;
      sync_reg <= RESET_VALUE;
    end
    else
    begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule // hsp_sync
`default_nettype wire

//--- verif/hsp_port_properties.sv
`timescale 1ns/1ps
`default_nettype none
module hsp_port_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic host_serial_clk,
  input wire logic host_select_n,
  input wire logic host_serial_out,
  input wire logic host_serial_out_oe,
  input wire logic test_port_select,
  input wire logic scan_enable,
  input wire logic checkword_write,
  input wire logic [15:0] processing_feature_disable
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence sel_idle;
    (host_select_n && !test_port_select) [*6];
  endsequence
  sequence in_scan;
    test_port_select [*5];
  endsequence
  oe_after_reset_a: assert property ($rose(rst_n) |-> !host_serial_out_oe)
    else $error("out driven after reset");
  oe_when_idle_a: assert property (sel_idle |-> !host_serial_out_oe)
    else $error("out driven while idle");
  cfg_hold_idle_a: assert property (sel_idle |-> $stable(processing_feature_disable))
    else $error("config changed while idle");
  scan_on_a: assert property (in_scan |-> scan_enable)
    else $error("scan not enabled");
  scan_off_a: assert property ((!test_port_select) [*5] |-> !scan_enable)
    else $error("scan enabled in port mode");
  read_msb_early_a:
    assert property ($rose(host_serial_out_oe) && !test_port_select |-> host_serial_clk)
    else $error("read msb late");
  read_shift_fall_a:
    assert property ($changed(host_serial_out) && $past(host_serial_out_oe) && host_serial_out_oe
      && !test_port_select |-> !host_serial_clk) else $error("read bit moved off falling edge");
  cw_one_pulse_a: assert property (checkword_write |=> !checkword_write)
    else $error("write pulse too long");
endmodule // hsp_port_properties
bind hsp_port hsp_port_properties chk
(
  .clk(clk),
  .rst_n(rst_n),
  .host_serial_clk(host_serial_clk),
  .host_select_n(host_select_n),
  .host_serial_out(host_serial_out),
  .host_serial_out_oe(host_serial_out_oe),
  .test_port_select(test_port_select),
  .scan_enable(scan_enable),
  .checkword_write(checkword_write),
  .processing_feature_disable(processing_feature_disable)
);
`default_nettype wire

//--- verif/hsp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module hsp_host_model (
  output logic host_serial_clk,
  output logic host_select_n,
  output logic host_serial_in,
  input wire logic host_serial_out
);
  localparam int HALF = 76;
  initial
  begin
    host_serial_clk = 1'b0;
    host_select_n = 1'b1;
    host_serial_in = 1'b0;
  end
  // n below 32 cuts the frame short, as an aborted access
  task automatic access(input logic rd, input logic [5:0] a, input logic [15:0] wd, input int n,
    output logic [15:0] q);
    logic [31:0] f;
    f = {rd, 9'h000, a, wd};
    q = 16'h0000;
    host_select_n = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      host_serial_in = f[31-i];
      #HALF host_serial_clk = 1'b1;
      if (i > 15) q = {q[14:0], host_serial_out};
      #HALF host_serial_clk = 1'b0;
    end
    host_serial_in = ~host_serial_in;
    #HALF host_select_n = 1'b1;
    #HALF;
  endtask
endmodule // hsp_host_model
`default_nettype wire

//--- verif/host_serial_register_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module host_serial_register_port_tb_top
  import hsp_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic test_port_select = 1'b0;
  logic scan_data_out = 1'b0;
  logic scan_data_out_en = 1'b0;
  logic [15:0] fault_flags_in = 16'h1357;
  logic [15:0] checkword_flags_in = 16'hC3A5;
  logic [15:0] picture_std_in = 16'h2468;
  logic [31:0] payload_id_in = 32'h9ABCDEF0;
  logic [63:0] line_sample_in = 64'h0123456789ABCDEF;
  logic host_serial_clk, host_select_n, host_serial_in, host_serial_out, host_serial_out_oe, sdo_pin;
  logic scan_enable, scan_mode_select, scan_clock, scan_data_in, scan_reset_n, checkword_write;
  logic [15:0] processing_feature_disable, fault_report_mask, checkword_write_data, rdat, cw_seen;
  logic [79:0] ancillary_packet_id_filters;
  logic [127:0] check_window_bounds;
  int mismatches = 0;
  int tests_run = 0;
  hsp_port uut
  (
    .clk(clk),
    .rst_n(rst_n),
    .host_serial_clk(host_serial_clk),
    .host_select_n(host_select_n),
    .host_serial_in(host_serial_in),
    .host_serial_out(host_serial_out),
    .host_serial_out_oe(host_serial_out_oe),
    .test_port_select(test_port_select),
    .scan_enable(scan_enable),
    .scan_mode_select(scan_mode_select),
    .scan_clock(scan_clock),
    .scan_data_in(scan_data_in),
    .scan_reset_n(scan_reset_n),
    .scan_data_out(scan_data_out),
    .scan_data_out_en(scan_data_out_en),
    .fault_flags_in(fault_flags_in),
    .checkword_flags_in(checkword_flags_in),
    .picture_std_in(picture_std_in),
    .payload_id_in(payload_id_in),
    .line_sample_in(line_sample_in),
    .processing_feature_disable(processing_feature_disable),
    .ancillary_packet_id_filters(ancillary_packet_id_filters),
    .check_window_bounds(check_window_bounds),
    .fault_report_mask(fault_report_mask),
    .checkword_write(checkword_write),
    .checkword_write_data(checkword_write_data)
  );
  hsp_host_model host (.host_serial_clk, .host_select_n, .host_serial_in, .host_serial_out(sdo_pin));
  // floating pin shows the inverse so a stale bit cannot pass
  assign sdo_pin = host_serial_out_oe ? host_serial_out : ~host_serial_out;
  initial
    forever #5 clk = ~clk;
  always @(posedge clk)
    if (checkword_write === 1'b1) cw_seen <= checkword_write_data;
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) $display("FAIL %0t got %0h exp %0h", $time, got, exp);
    mismatches += int'(got !== exp);
  endtask
  task automatic acc(input logic rd, input logic [5:0] a, input logic [15:0] wd, input int n);
    host.access(rd, a, wd, n, rdat);
    step(2);
  endtask
  task automatic t_cfg;
    logic [5:0] a[6];
    a = '{6'h00, 6'h05, 6'h09, 6'h12, 6'h19, 6'h1A};
    foreach (a[i])
    begin
      acc(1'b0, a[i], 16'hA5C0 + 16'(i), 32);
      acc(1'b1, a[i], 16'h0000, 32);
      cmp(rdat, 16'hA5C0 + 16'(i));
    end
    cmp({ancillary_packet_id_filters[79:64], ancillary_packet_id_filters[15:0]}, 32'hA5C2A5C1);
    cmp({check_window_bounds[127:112], check_window_bounds[15:0]}, 32'hA5C4A5C3);
    cmp({processing_feature_disable, fault_report_mask}, 32'hA5C0A5C5);
  endtask
  task automatic t_status;
    logic [5:0] a[7];
    logic [15:0] e[7];
    a = '{6'h01, 6'h03, 6'h04, 6'h0C, 6'h0D, 6'h0E, 6'h11};
    e = '{16'h1357, 16'hC3A5, 16'h2468, 16'hDEF0, 16'h9ABC, 16'hCDEF, 16'h0123};
    foreach (a[i])
    begin
      acc(1'b1, a[i], 16'h0000, 32);
      cmp(rdat, e[i]);
    end
  endtask
  task automatic t_unmapped;
    logic [5:0] a[4];
    a = '{6'h02, 6'h0A, 6'h0B, 6'h1B};
    foreach (a[i])
    begin
      acc(1'b0, a[i], 16'hFFFF, 32);
      acc(1'b1, a[i], 16'h0000, 32);
      cmp(rdat, HSP_UNMAPPED_READ);
    end
    acc(1'b0, 6'h03, 16'hBEEF, 32);
    cmp(cw_seen, 16'hBEEF);
    cmp(processing_feature_disable, 16'hA5C0);
  endtask
  task automatic t_abort;
    acc(1'b0, 6'h00, 16'hFFFF, 10);
    acc(1'b1, 6'h00, 16'h0000, 20);
    cmp(rdat, 16'h000A);
    cmp(host_serial_out_oe, 1'b0);
    acc(1'b0, 6'h00, 16'h1234, 32);
    cmp(processing_feature_disable, 16'h1234);
  endtask
  task automatic t_scan;
    test_port_select = 1'b1;
    step(6);
    cmp(scan_enable, 1'b1);
    cmp({scan_mode_select, scan_clock, scan_reset_n}, 3'b101);
    cmp(scan_data_in, host_serial_in);
    acc(1'b0, 6'h00, 16'hFFFF, 32);
    scan_data_out = 1'b1;
    scan_data_out_en = 1'b1;
    step(4);
    cmp({host_serial_out_oe, host_serial_out}, 2'b11);
    scan_data_out_en = 1'b0;
    test_port_select = 1'b0;
    step(6);
    cmp(processing_feature_disable, 16'h1234);
    cmp({scan_enable, scan_mode_select, scan_clock, scan_data_in, scan_reset_n}, 5'b01011);
  endtask
  task automatic t_reset;
    test_port_select = 1'b1;
    rst_n = 1'b0;
    step(1);
    cmp({host_serial_out_oe, scan_enable}, 2'b00);
    cmp(scan_reset_n, 1'b0);
    cmp({processing_feature_disable, fault_report_mask}, 32'h0);
    step(11);
    test_port_select = 1'b0;
    // reset held for cycles rather than a full millisecond to keep the run short
    rst_n = 1'b1;
    step(4);
    acc(1'b1, 6'h1A, 16'h0000, 32);
    cmp(rdat, HSP_CFG_RESET);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    step(12);
    // power-up reset shortened to cycles to keep the run short
    rst_n = 1'b1;
    step(4);
    t_cfg;
    t_status;
    t_unmapped;
    t_abort;
    t_scan;
    t_reset;
    print_verdict;
  end
  // about 33 accesses of 5.0 us each; allow six times that
  initial
  begin
    #1000000;
    mismatches++;
    print_verdict;
  end
endmodule // host_serial_register_port_tb_top
`default_nettype wire
